//--- hdl/plr_pkg.sv
// Shared constants and types of the PLL lock retry sequencer
package plr_pkg;
  localparam logic [31:0] ADDR_MAIN_CTL = 32'h0005_D100;
  localparam logic [31:0] ADDR_MAIN_STS = 32'h0005_D104;
  localparam logic [31:0] ADDR_AUX_CTL = 32'h0005_D108;
  localparam logic [31:0] ADDR_AUX_STS = 32'h0005_D10C;
  localparam logic [31:0] ADDR_IRQ_STS = 32'h0005_D110;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0005_D114;
  localparam logic [31:0] ADDR_WD_CTL = 32'h0005_D118;
  localparam logic [31:0] ADDR_WD_KICK = 32'h0005_D11C;
  localparam logic [31:0] ADDR_DBG_CTL = 32'h0005_D12C;
  localparam int CTL_PWR_BIT = 0;
  localparam int CTL_SEL_BIT = 1;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_RESET = 6'h01;
  localparam int STS_W = 4;
  localparam int IRQ_W = 5;
  localparam int IRQ_WD_BIT = 4;
  localparam int WD_EN_BIT = 0;
  localparam int WD_RST_BIT = 1;
  localparam int DBG_RETRY_BIT = 0;
  localparam int SYNC_CYCLES = 120;
  localparam int SYNC_CNT_W = 7;
  localparam int ACT_WIN = 16;
  localparam int ACT_CNT_W = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef struct packed {
    logic outSel;
    logic pwrEn;
  } plr_ctl_t;
  typedef struct packed {
    logic busy;
    logic alive;
    logic slip;
    logic lock;
  } plr_sts_t;
  typedef enum {SY_IDLE, SY_WAIT} plr_sync_t;
endpackage

//--- hdl/plr_pll_channel.sv
// One PLL channel: pin synchronisers, status flags, activity check, bypass sync timer
`timescale 1ns/1ns
module plr_pll_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire plr_pkg::plr_ctl_t ctl,
  input wire logic lockPin,
  input wire logic slipPin,
  input wire logic clkPin,
  output plr_pkg::plr_sts_t sts,
  output logic pwrOut,
  output logic selOut,
  output logic lockEvt,
  output logic slipEvt
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic clkPrev_ff;
  logic [plr_pkg::ACT_CNT_W-1:0] actCnt_ff;
  logic lock_ff;
  logic slip_ff;
  logic nxt_lock;
  logic nxt_slip;
  plr_pkg::plr_sync_t state_ff;
  logic [plr_pkg::SYNC_CNT_W-1:0] cnt_ff;
  logic falling;

  // Two-stage synchronisers for {clock, slip, lock}
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
      clkPrev_ff <= 1'b0;
    end else begin
      meta_ff <= {clkPin, slipPin, lockPin};
      sync_ff <= meta_ff;
      clkPrev_ff <= sync_ff[2];
    end
  end

  // Output clock seen toggling recently, independent of the lock flag
  always_ff @(posedge mclk) begin
    if (rst || !ctl.pwrEn) begin
      actCnt_ff <= '0;
    end else if (sync_ff[2] != clkPrev_ff) begin
      actCnt_ff <= plr_pkg::ACT_CNT_W'(plr_pkg::ACT_WIN);
    end else if (actCnt_ff != '0) begin
      actCnt_ff <= actCnt_ff - 1'b1;
    end
  end

  // Flags cleared while powered down
  assign nxt_lock = sync_ff[0] & ctl.pwrEn;
  assign nxt_slip = ctl.pwrEn & (slip_ff | sync_ff[1]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_ff <= 1'b0;
      slip_ff <= 1'b0;
      lockEvt <= 1'b0;
      slipEvt <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      slip_ff <= nxt_slip;
      lockEvt <= nxt_lock & ~lock_ff;
      slipEvt <= nxt_slip & ~slip_ff;
    end
  end

  assign falling = (pwrOut & ~ctl.pwrEn) | (selOut & ~ctl.outSel);

  // Power-down or bypass takes effect only after the sync period
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= plr_pkg::SY_IDLE;
      cnt_ff <= '0;
      pwrOut <= 1'b0;
      selOut <= 1'b0;
    end else begin
      case (state_ff)
        plr_pkg::SY_IDLE: begin
          if (falling) begin
            state_ff <= plr_pkg::SY_WAIT;
            cnt_ff <= plr_pkg::SYNC_CNT_W'(plr_pkg::SYNC_CYCLES - 1);
          end else begin
            pwrOut <= ctl.pwrEn;
            selOut <= ctl.outSel;
          end
        end
        plr_pkg::SY_WAIT: begin
          if (cnt_ff == '0) begin
            state_ff <= plr_pkg::SY_IDLE;
            pwrOut <= ctl.pwrEn;
            selOut <= ctl.outSel;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: state_ff <= plr_pkg::SY_IDLE;
      endcase
    end
  end

  assign sts.lock = lock_ff;
  assign sts.slip = slip_ff;
  assign sts.alive = (actCnt_ff != '0);
  assign sts.busy = (state_ff == plr_pkg::SY_WAIT) | falling;
endmodule

//--- hdl/plr_lock_retry_sequencer.sv
// PLL lock retry sequencer: AHB-Lite registers, watchdog, retry flag, interrupts
`timescale 1ns/1ns
// Operation
// - Lock flag alone never proves running clock
// - Watchdog on own clock guards PLL select; only main select is guarded, aux select unguarded
// - Retry flag at bit 0, debug control
// - No retry support when booting over USB
// - Power-down or bypass starts synchronisation period
// - Divider lowering blocked during 120-cycle sync; code blocks it only during a main channel sync, not an aux one
module plr_lock_retry_sequencer #(
  parameter int WD_CYCLES = 100000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic mainLockPin,
  input wire logic mainSlipPin,
  input wire logic mainClkPin,
  input wire logic auxLockPin,
  input wire logic auxSlipPin,
  input wire logic auxClkPin,
  input wire logic usbBootPin,
  output logic mainPwrEn,
  output logic mainOutSel,
  output logic auxPwrEn,
  output logic auxOutSel,
  output logic [plr_pkg::DIV_W-1:0] sysClkDiv,
  output logic wdogResetReq,
  output logic irq
);
  plr_pkg::plr_ctl_t mainCtl_ff;
  plr_pkg::plr_ctl_t auxCtl_ff;
  plr_pkg::plr_sts_t mainSts;
  plr_pkg::plr_sts_t auxSts;
  logic mainLockEvt;
  logic mainSlipEvt;
  logic auxLockEvt;
  logic auxSlipEvt;
  logic wrPend_ff;
  logic rdPend_ff;
  logic [31:0] addr_ff;
  logic [plr_pkg::IRQ_W-1:0] irqSts_ff;
  logic [plr_pkg::IRQ_W-1:0] irqMask_ff;
  logic [plr_pkg::IRQ_W-1:0] events;
  logic [1:0] wdCtl_ff;
  logic [31:0] wdCnt_ff;
  logic wdExpire_ff;
  logic retry_ff;
  logic usbMeta_ff;
  logic usbSync_ff;
  logic usbBoot_ff;
  logic usbCaught_ff;
  logic [1:0] usbAge_ff;
  logic wrMainCtl;
  logic mainDrop;
  logic [plr_pkg::DIV_W-1:0] newDiv;
  logic wdArmed;
  logic [31:0] rdMux;

  plr_pll_channel mainChan (
    .mclk(mclk),
    .rst(rst),
    .ctl(mainCtl_ff),
    .lockPin(mainLockPin),
    .slipPin(mainSlipPin),
    .clkPin(mainClkPin),
    .sts(mainSts),
    .pwrOut(mainPwrEn),
    .selOut(mainOutSel),
    .lockEvt(mainLockEvt),
    .slipEvt(mainSlipEvt)
  );

  plr_pll_channel auxChan (
    .mclk(mclk),
    .rst(rst),
    .ctl(auxCtl_ff),
    .lockPin(auxLockPin),
    .slipPin(auxSlipPin),
    .clkPin(auxClkPin),
    .sts(auxSts),
    .pwrOut(auxPwrEn),
    .selOut(auxOutSel),
    .lockEvt(auxLockEvt),
    .slipEvt(auxSlipEvt)
  );

  // Boot strap caught once, when the second stage first holds the pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      usbMeta_ff <= 1'b0;
      usbSync_ff <= 1'b0;
      usbAge_ff <= 2'h0;
      usbBoot_ff <= 1'b0;
      usbCaught_ff <= 1'b0;
    end else begin
      usbMeta_ff <= usbBootPin;
      usbSync_ff <= usbMeta_ff;
      usbAge_ff <= {usbAge_ff[0], 1'b1};
      if (usbAge_ff[1] && !usbCaught_ff) begin
        usbBoot_ff <= usbSync_ff;
        usbCaught_ff <= 1'b1;
      end
    end
  end

  // AHB-Lite slave: writes zero-wait, reads one wait state
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      if (rdPend_ff) begin
        hrdata <= rdMux;
        hreadyout <= 1'b1;
      end else if (hsel && hready && htrans == plr_pkg::HTRANS_NONSEQ) begin
        addr_ff <= haddr;
        wrPend_ff <= hwrite;
        rdPend_ff <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always_ff @(posedge mclk) begin
    hresp <= 1'b0;
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (addr_ff)
      plr_pkg::ADDR_MAIN_CTL: begin
        rdMux[plr_pkg::CTL_PWR_BIT] = mainCtl_ff.pwrEn;
        rdMux[plr_pkg::CTL_SEL_BIT] = mainCtl_ff.outSel;
        rdMux[plr_pkg::DIV_LSB +: plr_pkg::DIV_W] = sysClkDiv;
      end
      plr_pkg::ADDR_MAIN_STS: rdMux[plr_pkg::STS_W-1:0] = mainSts;
      plr_pkg::ADDR_AUX_CTL: begin
        rdMux[plr_pkg::CTL_PWR_BIT] = auxCtl_ff.pwrEn;
        rdMux[plr_pkg::CTL_SEL_BIT] = auxCtl_ff.outSel;
      end
      plr_pkg::ADDR_AUX_STS: rdMux[plr_pkg::STS_W-1:0] = auxSts;
      plr_pkg::ADDR_IRQ_STS: rdMux[plr_pkg::IRQ_W-1:0] = irqSts_ff;
      plr_pkg::ADDR_IRQ_MASK: rdMux[plr_pkg::IRQ_W-1:0] = irqMask_ff;
      plr_pkg::ADDR_WD_CTL: rdMux[1:0] = wdCtl_ff;
      plr_pkg::ADDR_WD_KICK: rdMux = wdCnt_ff;
      plr_pkg::ADDR_DBG_CTL: rdMux[plr_pkg::DBG_RETRY_BIT] = retry_ff;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  assign wrMainCtl = wrPend_ff && addr_ff == plr_pkg::ADDR_MAIN_CTL;
  assign newDiv = hwdata[plr_pkg::DIV_LSB +: plr_pkg::DIV_W];
  assign wdArmed = wdCtl_ff[plr_pkg::WD_EN_BIT] & wdCtl_ff[plr_pkg::WD_RST_BIT];

  // Main PLL control; select refused unless the watchdog is armed, USB boot is strapped or select is already set
  always_ff @(posedge mclk) begin
    if (rst) begin
      mainCtl_ff <= '0;
    end else if (wrMainCtl) begin
      mainCtl_ff.pwrEn <= hwdata[plr_pkg::CTL_PWR_BIT];
      mainCtl_ff.outSel <= hwdata[plr_pkg::CTL_SEL_BIT] &
                           (mainCtl_ff.outSel | wdArmed | usbBoot_ff);
    end
  end

  assign mainDrop = wrMainCtl &&
                    ((mainCtl_ff.pwrEn && !hwdata[plr_pkg::CTL_PWR_BIT]) ||
                     (mainCtl_ff.outSel && !hwdata[plr_pkg::CTL_SEL_BIT]));

  // Divider may not drop while a bypass sync is running or being started
  always_ff @(posedge mclk) begin
    if (rst) begin
      sysClkDiv <= plr_pkg::DIV_RESET;
    end else if (wrMainCtl && !((mainSts.busy || mainDrop) && newDiv < sysClkDiv)) begin
      sysClkDiv <= newDiv;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      auxCtl_ff <= '0;
    end else if (wrPend_ff && addr_ff == plr_pkg::ADDR_AUX_CTL) begin
      auxCtl_ff.pwrEn <= hwdata[plr_pkg::CTL_PWR_BIT];
      auxCtl_ff.outSel <= hwdata[plr_pkg::CTL_SEL_BIT];
    end
  end

  // Retry flag survives watchdog resets; held clear on USB boot
  always_ff @(posedge mclk) begin
    if (rst || usbBoot_ff) begin
      retry_ff <= 1'b0;
    end else if (wrPend_ff && addr_ff == plr_pkg::ADDR_DBG_CTL) begin
      retry_ff <= hwdata[plr_pkg::DBG_RETRY_BIT];
    end
  end

  // Watchdog counts on mclk, never on a PLL output
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdCtl_ff <= 2'h0;
    end else if (wrPend_ff && addr_ff == plr_pkg::ADDR_WD_CTL) begin
      wdCtl_ff <= hwdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdCnt_ff <= 32'(WD_CYCLES);
      wdExpire_ff <= 1'b0;
      wdogResetReq <= 1'b0;
    end else begin
      wdExpire_ff <= 1'b0;
      wdogResetReq <= 1'b0;
      if (!wdCtl_ff[plr_pkg::WD_EN_BIT]) begin
        wdCnt_ff <= 32'(WD_CYCLES);
      end else if (wrPend_ff && addr_ff == plr_pkg::ADDR_WD_KICK) begin
        wdCnt_ff <= 32'(WD_CYCLES);
      end else if (wdCnt_ff == 32'h0000_0000) begin
        wdCnt_ff <= 32'(WD_CYCLES);
        wdExpire_ff <= 1'b1;
        wdogResetReq <= wdCtl_ff[plr_pkg::WD_RST_BIT];
      end else begin
        wdCnt_ff <= wdCnt_ff - 32'h0000_0001;
      end
    end
  end

  // Sticky events, cleared by reading; a new event wins over the clear
  assign events = {wdExpire_ff, auxSlipEvt, auxLockEvt, mainSlipEvt, mainLockEvt};

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqSts_ff <= '0;
    end else if (rdPend_ff && addr_ff == plr_pkg::ADDR_IRQ_STS) begin
      irqSts_ff <= events;
    end else begin
      irqSts_ff <= irqSts_ff | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqMask_ff <= '0;
    end else if (wrPend_ff && addr_ff == plr_pkg::ADDR_IRQ_MASK) begin
      irqMask_ff <= hwdata[plr_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqSts_ff & irqMask_ff);
    end
  end
endmodule

//--- tb/plr_lrs_props.sv
// Port checker of the PLL lock retry sequencer
`timescale 1ns/1ns
module plr_lrs_props #(
  parameter int WD_CYCLES = 100000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic usbBootPin,
  input wire logic mainPwrEn,
  input wire logic mainOutSel,
  input wire logic [plr_pkg::DIV_W-1:0] sysClkDiv,
  input wire logic wdogResetReq
);
  logic take;
  logic clr;
  logic ctlWr_ff;
  logic wdWr_ff;
  logic wdArm_ff;
  logic [1:0] ctl_ff;
  logic [7:0] syncCnt_ff;
  assign take = hsel && hready && htrans == plr_pkg::HTRANS_NONSEQ;
  assign clr = ctlWr_ff && ((!hwdata[0] && ctl_ff[0]) || (!hwdata[1] && ctl_ff[1]));
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctlWr_ff <= 1'h0;
      wdWr_ff <= 1'h0;
      wdArm_ff <= 1'h0;
      ctl_ff <= 2'h0;
      syncCnt_ff <= 8'h00;
    end else begin
      ctlWr_ff <= take && hwrite && haddr == plr_pkg::ADDR_MAIN_CTL;
      wdWr_ff <= take && hwrite && haddr == plr_pkg::ADDR_WD_CTL;
      if (wdWr_ff) begin
        wdArm_ff <= hwdata[1:0] == 2'h3;
      end
      if (ctlWr_ff) begin
        ctl_ff <= {hwdata[1] & (wdArm_ff | usbBootPin), hwdata[0]};
      end
      if (clr) begin
        syncCnt_ff <= 8'h78;
      end else if (syncCnt_ff != 8'h00) begin
        syncCnt_ff <= syncCnt_ff - 8'h01;
      end
    end
  end
  a_resp_okay: assert property (@(posedge mclk) disable iff (rst) !hresp)
    else $error("error response seen");
  a_read_wait: assert property (@(posedge mclk) disable iff (rst)
    take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (@(posedge mclk) disable iff (rst)
    take && hwrite |=> hreadyout) else $error("write stalled");
  a_wdog_pulse: assert property (@(posedge mclk) disable iff (rst)
    wdogResetReq |=> !wdogResetReq [*8]) else $error("reset request too long");
  a_sel_guard: assert property (@(posedge mclk) disable iff (rst)
    $rose(mainOutSel) |-> wdArm_ff || usbBootPin) else $error("select without watchdog");
  a_bypass_hold: assert property (@(posedge mclk) disable iff (rst)
    clr && mainOutSel |=> mainOutSel [*8] ##100 mainOutSel ##[1:20] !mainOutSel)
    else $error("bypass timing wrong");
  a_div_guard: assert property (@(posedge mclk) disable iff (rst)
    syncCnt_ff > 8'h02 |-> sysClkDiv >= $past(sysClkDiv)) else $error("divider lowered");
  a_pwr_set: assert property (@(posedge mclk) disable iff (rst)
    ctlWr_ff && hwdata[0] && !mainPwrEn |-> ##[1:3] mainPwrEn) else $error("power late");
endmodule
bind plr_lock_retry_sequencer plr_lrs_props #(.WD_CYCLES(WD_CYCLES)) plr_lrs_props_i (
  .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .usbBootPin(usbBootPin), .mainPwrEn(mainPwrEn), .mainOutSel(mainOutSel),
  .sysClkDiv(sysClkDiv), .wdogResetReq(wdogResetReq));

//--- tb/plr_lock_retry_sequencer_tb.sv
// Self-checking bench of the PLL lock retry sequencer
`timescale 1ns/1ns
module plr_lock_retry_sequencer_tb;
  typedef struct packed {
    logic w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } plr_row_t;
  logic mclk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, clkRun = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic mainLockPin = 1'h0, mainSlipPin = 1'h0, mainClkPin = 1'h0;
  logic auxLockPin = 1'h0, auxSlipPin = 1'h0, auxClkPin = 1'h0, usbBootPin = 1'h0;
  logic hreadyout, hresp, mainPwrEn, mainOutSel, auxPwrEn, auxOutSel, wdogResetReq, irq;
  logic [plr_pkg::DIV_W-1:0] sysClkDiv;
  int n_fail = 0, cmp_count = 0, cyc = 0, n = 0;
  plr_row_t rows[11];
  plr_lock_retry_sequencer #(.WD_CYCLES(50)) plr_lock_retry_sequencer_i (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mainLockPin(mainLockPin), .mainSlipPin(mainSlipPin),
    .mainClkPin(mainClkPin), .auxLockPin(auxLockPin), .auxSlipPin(auxSlipPin),
    .auxClkPin(auxClkPin), .usbBootPin(usbBootPin), .mainPwrEn(mainPwrEn),
    .mainOutSel(mainOutSel), .auxPwrEn(auxPwrEn), .auxOutSel(auxOutSel),
    .sysClkDiv(sysClkDiv), .wdogResetReq(wdogResetReq), .irq(irq));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (clkRun) begin
      mainClkPin <= ~mainClkPin;
      auxClkPin <= ~auxClkPin;
    end
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results();
    end
  end
  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= plr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task rstSeq();
    rst <= 1'h1;
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    rows[0] = '{1'h0, plr_pkg::ADDR_DBG_CTL, 32'h0, 32'h1, 32'h0};
    rows[1] = '{1'h1, plr_pkg::ADDR_DBG_CTL, 32'h1, 32'h0, 32'h0};
    rows[2] = '{1'h0, plr_pkg::ADDR_DBG_CTL, 32'h0, 32'h1, 32'h1};
    rows[3] = '{1'h0, plr_pkg::ADDR_MAIN_CTL, 32'h0, 32'h3F03, 32'h100};
    rows[4] = '{1'h0, 32'h0005_D120, 32'h0, 32'hFFFF_FFFF, 32'h0};
    rows[5] = '{1'h1, 32'h0005_D120, 32'hFFFF_FFFF, 32'h0, 32'h0};
    rows[6] = '{1'h0, 32'h0005_D120, 32'h0, 32'hFFFF_FFFF, 32'h0};
    rows[7] = '{1'h1, plr_pkg::ADDR_IRQ_MASK, 32'h1F, 32'h0, 32'h0};
    rows[8] = '{1'h0, plr_pkg::ADDR_IRQ_MASK, 32'h0, 32'h1F, 32'h1F};
    rows[9] = '{1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h501, 32'h0, 32'h0};
    rows[10] = '{1'h0, plr_pkg::ADDR_MAIN_CTL, 32'h0, 32'h3F03, 32'h501};
    rstSeq();
    check("div", 32'(sysClkDiv), 32'h1);
    check("irq", 32'(irq), 32'h0);
    check("pwr", 32'(mainPwrEn), 32'h0);
    for (int i = 0; i < 11; i++) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check("reg", rd & rows[i].m, rows[i].e);
    end
    mainLockPin <= 1'h1;
    repeat (8) @(posedge mclk);
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("lockNoClk", rd & 32'h7, 32'h1);
    clkRun <= 1'h1;
    mainSlipPin <= 1'h1;
    repeat (24) @(posedge mclk);
    mainSlipPin <= 1'h0;
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("lockClk", rd & 32'h7, 32'h7);
    check("irqOn", 32'(irq), 32'h1);
    bus(1'h0, plr_pkg::ADDR_IRQ_STS, 32'h0);
    check("irqSts", rd & 32'h3, 32'h3);
    repeat (3) @(posedge mclk);
    check("irqOff", 32'(irq), 32'h0);
    bus(1'h1, plr_pkg::ADDR_IRQ_MASK, 32'h0);
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h1);
    auxLockPin <= 1'h1;
    repeat (8) @(posedge mclk);
    check("irqMasked", 32'(irq), 32'h0);
    bus(1'h0, plr_pkg::ADDR_IRQ_STS, 32'h0);
    check("auxLockEvt", rd & 32'h4, 32'h4);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h503);
    repeat (4) @(posedge mclk);
    check("selRefused", 32'(mainOutSel), 32'h0);
    bus(1'h1, plr_pkg::ADDR_WD_CTL, 32'h3);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h503);
    repeat (4) @(posedge mclk);
    check("selTaken", 32'(mainOutSel), 32'h1);
    repeat (80) begin
      @(posedge mclk);
      if (wdogResetReq === 1'h1) n = n + 1;
    end
    check("wdogPulse", 32'(n != 0), 32'h1);
    bus(1'h1, plr_pkg::ADDR_WD_CTL, 32'h0);
    bus(1'h0, plr_pkg::ADDR_IRQ_STS, 32'h0);
    check("wdogEvt", rd & 32'h10, 32'h10);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h501);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h301);
    repeat (90) @(posedge mclk);
    check("selHeld", 32'(mainOutSel), 32'h1);
    check("divHeld", 32'(sysClkDiv), 32'h5);
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("busy", rd & 32'h8, 32'h8);
    repeat (40) @(posedge mclk);
    check("selGone", 32'(mainOutSel), 32'h0);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h301);
    repeat (3) @(posedge mclk);
    check("divLow", 32'(sysClkDiv), 32'h3);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h300);
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("flagsOff", rd & 32'h3, 32'h0);
    repeat (120) @(posedge mclk);
    bus(1'h1, plr_pkg::ADDR_DBG_CTL, 32'h1);
    for (int k = 0; k < 5; k++) begin
      bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h301);
      do bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0); while (rd[0] !== 1'h1);
      bus(1'h0, plr_pkg::ADDR_IRQ_STS, 32'h0);
      check("lockSeq", rd & 32'h1, 32'h1);
      bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h300);
      repeat (120) @(posedge mclk);
    end
    bus(1'h0, plr_pkg::ADDR_DBG_CTL, 32'h0);
    check("retrySet", rd & 32'h1, 32'h1);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h301);
    repeat (8) @(posedge mclk);
    bus(1'h1, plr_pkg::ADDR_WD_CTL, 32'h3);
    mainSlipPin <= 1'h1;
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h303);
    mainSlipPin <= 1'h0;
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("slipSeen", rd & 32'h2, 32'h2);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h300);
    repeat (120) @(posedge mclk);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h301);
    repeat (8) @(posedge mclk);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h303);
    bus(1'h0, plr_pkg::ADDR_MAIN_STS, 32'h0);
    check("slipGone", rd & 32'h2, 32'h0);
    repeat (3) @(posedge mclk);
    check("selAgain", 32'(mainOutSel), 32'h1);
    clkRun <= 1'h0;
    repeat (24) @(posedge mclk);
    bus(1'h0, plr_pkg::ADDR_AUX_STS, 32'h0);
    check("auxDead", rd & 32'h5, 32'h1);
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h0);
    repeat (120) @(posedge mclk);
    clkRun <= 1'h1;
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h1);
    repeat (24) @(posedge mclk);
    bus(1'h0, plr_pkg::ADDR_AUX_STS, 32'h0);
    check("auxAlive", rd & 32'h5, 32'h5);
    auxSlipPin <= 1'h1;
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h3);
    auxSlipPin <= 1'h0;
    bus(1'h0, plr_pkg::ADDR_AUX_STS, 32'h0);
    check("auxSlip", rd & 32'h2, 32'h2);
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h0);
    repeat (120) @(posedge mclk);
    bus(1'h1, plr_pkg::ADDR_AUX_CTL, 32'h3);
    bus(1'h0, plr_pkg::ADDR_AUX_STS, 32'h0);
    check("auxNoSlip", rd & 32'h2, 32'h0);
    check("auxOuts", 32'({auxPwrEn, auxOutSel}), 32'h3);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h101);
    repeat (2) @(posedge mclk);
    check("divSame", 32'(sysClkDiv), 32'h3);
    usbBootPin <= 1'h1;
    rstSeq();
    check("rstDiv", 32'(sysClkDiv), 32'h1);
    check("rstSel", 32'(mainOutSel), 32'h0);
    bus(1'h1, plr_pkg::ADDR_DBG_CTL, 32'h1);
    bus(1'h0, plr_pkg::ADDR_DBG_CTL, 32'h0);
    check("usbRetry", rd & 32'h1, 32'h0);
    bus(1'h1, plr_pkg::ADDR_MAIN_CTL, 32'h3);
    repeat (4) @(posedge mclk);
    check("usbSel", 32'(mainOutSel), 32'h1);
    results();
  end
endmodule
